// ==== verilog/interrupt_vector_priority_resolver.sv ====
// Interrupt vector mapping and priority resolution
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps

// Operation
// - Equal level: lowest vector number wins
// - Level bit raises whole module
// - Ties and intra-module order fixed
// - Address is vector times two or four
// - Pin request level bits, key shares 22
// - Vectors 24-27, break has no bit
// - Conversion end 28 under B7
// - Free-running timer vectors 48 to 54
// - Timer channels 64-66 and 68-70
// - Y/X timer pair vectors 72-75
// - Host buffer full vectors 76, 77
// - Serial channels four vectors from 80/84/88
// - I2C vectors 92, 93, 94
// - Pin requests 0-7 on vectors 16-23
module interrupt_vector_priority_resolver (
    input  wire logic                              core_clk,
    input  wire logic                              rst,
    input  wire logic                              advanced_mode,
    input  wire vec_pkg::irq_req_t                 req,
    input  wire logic [1:0]                        lvl_addr,
    input  wire logic [7:0]                        lvl_wdata,
    input  wire logic                              lvl_wr,
    input  wire logic                              lvl_rd,
    output logic      [7:0]                        lvl_rdata,
    output vec_pkg::vec_out_t                      vec_out
);
    import vec_pkg::*;

    // ------------------------------------------------------------
    // Priority-level registers
    // ------------------------------------------------------------
    priority_level_register_t lvl_r;
    priority_level_register_t lvl_nxt;
    logic [7:0]               rdata_r;
    logic [7:0]               rdata_nxt;

    always_comb begin
        lvl_nxt = lvl_r;
        rdata_nxt = 8'h00;
        if (lvl_wr) begin
            unique case (lvl_addr)
                2'h0: lvl_nxt.a = lvl_wdata;
                2'h1: lvl_nxt.b = lvl_wdata;
                2'h2: lvl_nxt.c = lvl_wdata;
                default: ;
            endcase
        end
        if (lvl_rd) begin
            unique case (lvl_addr)
                2'h0: rdata_nxt = lvl_r.a;
                2'h1: rdata_nxt = lvl_r.b;
                2'h2: rdata_nxt = lvl_r.c;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lvl_r <= '{a: LVL_RESET, b: LVL_RESET, c: LVL_RESET};
            rdata_r <= 8'h00;
        end else begin
            lvl_r <= lvl_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign lvl_rdata = rdata_r;

    // ------------------------------------------------------------
    // Per-vector request and level maps
    // ------------------------------------------------------------
    logic [NREQ-1:0] pend;
    logic [NREQ-1:0] hi;

    always_comb begin
        pend = '0;
        hi = '0;
        pend[VEC_NMI] = req.nmi;
        for (int i = 0; i < 8; i++) begin
            pend[VEC_IRQ0 + i] = req.irq[i];
        end
        pend[VEC_KEY] = req.irq[6] | req.key_sense_inputs;
        hi[VEC_IRQ0] = lvl_r.a[A_IRQ0];
        hi[VEC_IRQ0 + 1] = lvl_r.a[A_IRQ1];
        for (int i = 0; i < 2; i++) begin
            hi[VEC_IRQ0 + 2 + i] = lvl_r.a[A_IRQ23];
            hi[VEC_IRQ0 + 4 + i] = lvl_r.a[A_IRQ45];
            hi[VEC_IRQ0 + 6 + i] = lvl_r.a[A_IRQ67];
        end
        pend[VEC_SWDT] = req.sw_transfer_end_req;
        pend[VEC_WDT0] = req.watchdog0_overflow_req;
        pend[VEC_WDT1] = req.watchdog1_overflow_req;
        pend[VEC_PCBRK] = req.pc_break_req;
        hi[VEC_SWDT] = lvl_r.a[A_SWDT];
        hi[VEC_WDT0] = lvl_r.a[A_WDT0];
        hi[VEC_WDT1] = lvl_r.a[A_WDT1];
        pend[VEC_ADC] = req.conversion_end_req;
        hi[VEC_ADC] = lvl_r.b[B_ADC];
        for (int i = 0; i < 7; i++) begin
            pend[VEC_FRT + i] = req.frt_req[i];
            hi[VEC_FRT + i] = lvl_r.b[B_FRT];
        end
        for (int i = 0; i < 3; i++) begin
            pend[VEC_TMR0 + i] = req.tmr0_req[i];
            hi[VEC_TMR0 + i] = lvl_r.b[B_TMR0];
            pend[VEC_TMR1 + i] = req.tmr1_req[i];
            hi[VEC_TMR1 + i] = lvl_r.b[B_TMR1];
        end
        for (int i = 0; i < 4; i++) begin
            pend[VEC_TMRYX + i] = req.tmryx_req[i];
            hi[VEC_TMRYX + i] = lvl_r.b[B_TMRYX];
        end
        pend[VEC_HOST] = req.host_buf1_full_req;
        pend[VEC_HOST + 1] = req.host_buf2_full_req;
        hi[VEC_HOST] = lvl_r.b[B_HOST];
        hi[VEC_HOST + 1] = lvl_r.b[B_HOST];
        for (int i = 0; i < 4; i++) begin
            pend[VEC_SCI0 + i] = req.serial0_req[i];
            pend[VEC_SCI1 + i] = req.serial1_req[i];
            pend[VEC_SCI2 + i] = req.serial2_req[i];
            hi[VEC_SCI0 + i] = lvl_r.c[C_SCI0];
            hi[VEC_SCI1 + i] = lvl_r.c[C_SCI1];
            hi[VEC_SCI2 + i] = lvl_r.c[C_SCI2];
        end
        pend[VEC_I2C0] = req.i2c0_byte_done_req;
        pend[VEC_I2C0 + 1] = req.i2c_format_switch_req;
        pend[VEC_I2C1] = req.i2c1_byte_done_req;
        hi[VEC_I2C0] = lvl_r.c[C_I2C0];
        hi[VEC_I2C0 + 1] = lvl_r.c[C_I2C0];
        hi[VEC_I2C1] = lvl_r.c[C_I2C1];
    end

    // ------------------------------------------------------------
    // Resolution
    // ------------------------------------------------------------
    logic [NREQ-1:0] cand;
    logic            found;
    logic [6:0]      win;
    vec_out_t        out_r;
    vec_out_t        out_nxt;

    always_comb begin
        cand = (|(pend & hi)) ? (pend & hi) : pend;
        if (pend[VEC_NMI]) begin
            cand = '0;
            cand[VEC_NMI] = 1'b1;
        end
        found = 1'b0;
        win = 7'h00;
        for (int i = NREQ - 1; i >= 0; i--) begin
            if (cand[i]) begin
                found = 1'b1;
                win = 7'(i);
            end
        end
        out_nxt.valid = found;
        out_nxt.number = found ? win : 7'h00;
        out_nxt.address = !found ? 24'h000000 :
            (advanced_mode ? (24'(win) << ADV_SHIFT)
                           : (24'(win) << NORM_SHIFT));
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out_r <= '0;
        end else begin
            out_r <= out_nxt;
        end
    end

    assign vec_out = out_r;

endmodule // interrupt_vector_priority_resolver

// ==== verilog/vec_pkg.sv ====
// Vector numbers, priority-level bit positions and request carrier types
package vec_pkg;

    localparam int VEC_W = 7;
    localparam int ADDR_W = 24;
    localparam int NREQ = 104;
    localparam int LVL_BITS = 8;

    // Fixed vector numbers
    localparam logic [6:0] VEC_NMI = 7'h07;
    localparam logic [6:0] VEC_IRQ0 = 7'h10;
    localparam logic [6:0] VEC_KEY = 7'h16;
    localparam logic [6:0] VEC_SWDT = 7'h18;
    localparam logic [6:0] VEC_WDT0 = 7'h19;
    localparam logic [6:0] VEC_WDT1 = 7'h1A;
    localparam logic [6:0] VEC_PCBRK = 7'h1B;
    localparam logic [6:0] VEC_ADC = 7'h1C;
    localparam logic [6:0] VEC_FRT = 7'h30;
    localparam logic [6:0] VEC_TMR0 = 7'h40;
    localparam logic [6:0] VEC_TMR1 = 7'h44;
    localparam logic [6:0] VEC_TMRYX = 7'h48;
    localparam logic [6:0] VEC_HOST = 7'h4C;
    localparam logic [6:0] VEC_SCI0 = 7'h50;
    localparam logic [6:0] VEC_SCI1 = 7'h54;
    localparam logic [6:0] VEC_SCI2 = 7'h58;
    localparam logic [6:0] VEC_I2C0 = 7'h5C;
    localparam logic [6:0] VEC_I2C1 = 7'h5E;

    // Vector address scaling: shift by 1 (normal) or 2 (advanced)
    localparam int NORM_SHIFT = 1;
    localparam int ADV_SHIFT = 2;

    // Priority-level bit positions, registers A, B, C
    localparam int A_IRQ0 = 7;
    localparam int A_IRQ1 = 6;
    localparam int A_IRQ23 = 5;
    localparam int A_IRQ45 = 4;
    localparam int A_IRQ67 = 3;
    localparam int A_SWDT = 2;
    localparam int A_WDT0 = 1;
    localparam int A_WDT1 = 0;
    localparam int B_ADC = 7;
    localparam int B_FRT = 6;
    localparam int B_TMR0 = 3;
    localparam int B_TMR1 = 2;
    localparam int B_TMRYX = 1;
    localparam int B_HOST = 0;
    localparam int C_SCI0 = 7;
    localparam int C_SCI1 = 6;
    localparam int C_SCI2 = 5;
    localparam int C_I2C0 = 4;
    localparam int C_I2C1 = 3;

    localparam logic [7:0] LVL_RESET = 8'h00;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
    } priority_level_register_t;

    typedef struct packed {
        logic       nmi;
        logic [7:0] irq;
        logic       key_sense_inputs;
        logic       sw_transfer_end_req;
        logic       watchdog0_overflow_req;
        logic       watchdog1_overflow_req;
        logic       pc_break_req;
        logic       conversion_end_req;
        logic [6:0] frt_req;
        logic [2:0] tmr0_req;
        logic [2:0] tmr1_req;
        logic [3:0] tmryx_req;
        logic       host_buf1_full_req;
        logic       host_buf2_full_req;
        logic [3:0] serial0_req;
        logic [3:0] serial1_req;
        logic [3:0] serial2_req;
        logic       i2c0_byte_done_req;
        logic       i2c_format_switch_req;
        logic       i2c1_byte_done_req;
    } irq_req_t;

    typedef struct packed {
        logic              valid;
        logic [VEC_W-1:0]  number;
        logic [ADDR_W-1:0] address;
    } vec_out_t;

endpackage

// ==== verification/ivpr_monitor.sv ====
// Checker of the resolver ports
`timescale 1ns/1ps
module ivpr_monitor (
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              advanced_mode,
    input wire vec_pkg::irq_req_t req,
    input wire logic [1:0]        lvl_addr,
    input wire logic [7:0]        lvl_wdata,
    input wire logic              lvl_wr,
    input wire logic              lvl_rd,
    input wire logic [7:0]        lvl_rdata,
    input wire vec_pkg::vec_out_t vec_out
);
    import vec_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [6:0] n;
    logic       any_req;
    assign n = vec_out.number;
    assign any_req = |req;
    chk_nmi_first: assert property (req.nmi |=> vec_out.valid && n == 7'h07)
        else $error("nmi lost");
    chk_addr_norm: assert property (vec_out.valid && !$past(advanced_mode)
        |-> vec_out.address == {16'h0000, n, 1'b0}) else $error("addr x2");
    chk_addr_adv: assert property (vec_out.valid && $past(advanced_mode)
        |-> vec_out.address == {15'h0000, n, 2'h0}) else $error("addr x4");
    chk_no_reserved: assert property (vec_out.valid |-> !(n inside
        {[7'h00:7'h06], [7'h08:7'h0F], [7'h1D:7'h2F], [7'h37:7'h3F], 7'h43,
        7'h47, 7'h4E, 7'h4F, [7'h5F:7'h67]})) else $error("reserved");
    chk_valid_track: assert property (1'b1 |=> vec_out.valid == $past(any_req))
        else $error("valid");
    chk_rdata_idle: assert property (!lvl_rd |=> lvl_rdata == 8'h00)
        else $error("rdata idle");
    chk_rdata_hole: assert property (lvl_rd && lvl_addr == 2'h3
        |=> lvl_rdata == 8'h00) else $error("rdata hole");
    chk_read_back: assert property (lvl_wr && lvl_addr != 2'h3 ##1 lvl_rd &&
        lvl_addr == $past(lvl_addr) |=> lvl_rdata == $past(lvl_wdata, 2))
        else $error("readback");
    chk_break_vec: assert property ($onehot(req) && req.pc_break_req
        |=> n == 7'h1B) else $error("break vector");
endmodule // ivpr_monitor

bind interrupt_vector_priority_resolver ivpr_monitor u_mon (
    .core_clk(core_clk), .rst(rst), .advanced_mode(advanced_mode),
    .req(req), .lvl_addr(lvl_addr), .lvl_wdata(lvl_wdata), .lvl_wr(lvl_wr),
    .lvl_rd(lvl_rd), .lvl_rdata(lvl_rdata), .vec_out(vec_out));

// ==== verification/cpu_vec_sink.sv ====
// CPU side model that takes offered vectors
`timescale 1ns/1ps
module cpu_vec_sink (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire vec_pkg::vec_out_t vec_out,
    output logic [6:0]             taken_r
);
    import vec_pkg::*;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            taken_r <= 7'h00;
        end else if (vec_out.valid) begin
            taken_r <= vec_out.number;
        end
    end
endmodule // cpu_vec_sink

// ==== verification/tb.sv ====
// Self-checking bench of the resolver
`timescale 1ns/1ps
module tb;
    import vec_pkg::*;
    typedef struct {logic [7:0] a, b, c; int p, q; logic [6:0] e;} row_t;
    row_t rows [8] = '{'{8'h00, 8'h00, 8'h00, 0, 33, 7'h36},
        '{8'h00, 8'h00, 8'h08, 0, 33, 7'h5E}, '{8'h00, 8'h48, 8'h00, 24, 33, 7'h36},
        '{8'h00, 8'h08, 8'h00, 24, 33, 7'h40}, '{8'h00, 8'h40, 8'h00, 27, 33, 7'h30},
        '{8'hFF, 8'hFF, 8'hFF, 48, 0, 7'h07}, '{8'hFF, 8'hFF, 8'hFF, 35, 0, 7'h5E},
        '{8'h20, 8'h00, 8'h00, 41, 43, 7'h13}};
    logic       core_clk = 1'b0;
    logic       rst = 1'b1;
    logic       advanced_mode = 1'b0;
    irq_req_t   req = '0;
    logic [1:0] lvl_addr = 2'h0;
    logic [7:0] lvl_wdata = 8'h00;
    logic       lvl_wr = 1'b0;
    logic       lvl_rd = 1'b0;
    logic [7:0] lvl_rdata;
    vec_out_t   vec_out;
    logic [6:0] taken_r;
    int         err_count = 0;
    int         comparisons = 0;
    always #2.5 core_clk = ~core_clk;
    interrupt_vector_priority_resolver u_dut (.core_clk(core_clk), .rst(rst),
        .advanced_mode(advanced_mode), .req(req), .lvl_addr(lvl_addr),
        .lvl_wdata(lvl_wdata), .lvl_wr(lvl_wr), .lvl_rd(lvl_rd),
        .lvl_rdata(lvl_rdata), .vec_out(vec_out));
    cpu_vec_sink u_cpu (.core_clk(core_clk), .rst(rst), .vec_out(vec_out),
        .taken_r(taken_r));
    function automatic logic [6:0] vec_of(int b);
        if (b == 48) return 7'h07;
        if (b >= 40) return 7'(b - 24);
        if (b == 39) return 7'h16;
        if (b >= 34) return 7'(62 - b);
        if (b >= 27) return 7'(b + 21);
        if (b >= 24) return 7'(b + 40);
        if (b >= 21) return 7'(b + 47);
        if (b >= 17) return 7'(b + 55);
        if (b >= 15) return 7'(92 - b);
        if (b >= 11) return 7'(b + 69);
        if (b >= 7) return 7'(b + 77);
        if (b >= 3) return 7'(b + 85);
        return 7'(94 - b);
    endfunction
    task automatic cmp(logic [31:0] g, logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(logic w, logic r, logic [1:0] a, logic [7:0] d);
        @(posedge core_clk);
        lvl_wr <= w;
        lvl_rd <= r;
        lvl_addr <= a;
        lvl_wdata <= d;
    endtask
    task automatic rd(logic [1:0] a, logic [7:0] e);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, 2'h0, 8'h00);
        #1 cmp({24'h0, lvl_rdata}, {24'h0, e});
    endtask
    task automatic apply(logic [7:0] a, b, c, irq_req_t r, logic m);
        bus(1'b1, 1'b0, 2'h0, a);
        bus(1'b1, 1'b0, 2'h1, b);
        bus(1'b1, 1'b0, 2'h2, c);
        bus(1'b0, 1'b0, 2'h0, 8'h00);
        req <= r;
        advanced_mode <= m;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic chk_vec(logic [6:0] n, logic m);
        cmp({vec_out.valid, vec_out.number, vec_out.address}, {1'b1, n,
            m ? {15'h0000, n, 2'h0} : {16'h0000, n, 1'b0}});
    endtask
    task automatic close_out;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        for (int m = 0; m < 2; m++) begin
            for (int b = 0; b < 49; b++) begin
                apply(8'h00, 8'h00, 8'h00, irq_req_t'(49'h1 << b), m[0]);
                chk_vec(vec_of(b), m[0]);
            end
        end
        foreach (rows[i]) begin
            apply(rows[i].a, rows[i].b, rows[i].c, irq_req_t'((49'h1 << rows[i].p)
                | (49'h1 << rows[i].q)), 1'b0);
            chk_vec(rows[i].e, 1'b0);
        end
        cmp({25'h0, taken_r}, {25'h0, 7'h13});
        rst <= 1'b1;
        #1 cmp({vec_out.valid, vec_out.number, vec_out.address}, 32'h0);
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        rd(2'h2, 8'h00);
        bus(1'b1, 1'b0, 2'h3, 8'hFF);
        rd(2'h3, 8'h00);
        bus(1'b1, 1'b0, 2'h1, 8'hA5);
        rd(2'h1, 8'hA5);
        close_out;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        close_out;
    end
endmodule // tb
